/* File: include/lsap_pkg.sv */
package lsap_pkg;
    localparam int VA_W = 64;
    localparam int PA_W = 40;
    localparam int SIZE_W = 3;
    localparam int REG_SEL_W = 5;
    localparam int COP_NUM_W = 2;
    localparam int FUNC_W = 25;
    localparam int TLB_ENTRIES = 8;
    localparam int PAGE_SHIFT = 12;
    localparam int CCA_W = 3;
    // Access size code: byte count minus one
    localparam logic [2:0] SZ_BYTE = 3'h0;
    localparam logic [2:0] SZ_HALF = 3'h1;
    localparam logic [2:0] SZ_WORD = 3'h3;
    localparam logic [2:0] SZ_DOUBLE = 3'h7;
    // Unmapped window: top address bits select it
    localparam logic [1:0] UNMAPPED_TAG = 2'h2;
    localparam int UNMAPPED_TAG_POS = 62;
    localparam int UNMAPPED_CCA_POS = 59;
    localparam logic [2:0] CCA_UNCACHED = 3'h2;
    localparam int FILL_BYTES_LOG2 = 5;
    // Operation codes
    localparam logic [2:0] OP_LOAD = 3'h0;
    localparam logic [2:0] OP_STORE = 3'h1;
    localparam logic [2:0] OP_CP_LW = 3'h2;
    localparam logic [2:0] OP_CP_LD = 3'h3;
    localparam logic [2:0] OP_CP_SW = 3'h4;
    localparam logic [2:0] OP_CP_SD = 3'h5;
    localparam logic [2:0] OP_CP_FN = 3'h6;
    typedef enum logic [1:0] {LSAP_IDLE, LSAP_MEM, LSAP_DONE} lsap_state_e;
endpackage

/* File: src/lsap_path.sv */
`timescale 1ns/1ns
// Contract
// [RULE1] Lowest byte address names multi-byte objects
// [RULE2] Byte lanes from size and low bits
// [RULE3] Memory element is register wide, aligned
// [RULE4] Uncached load reads only referenced bytes
// [RULE5] Cached miss fills at least element
// [RULE6] Unmapped region translates directly from address
// [RULE7] Missing or forbidden mapping raises exception
// [RULE8] Coprocessor word load passes 32 bits
// [RULE9] Coprocessor double load passes 64 bits
// [RULE10] Coprocessor returns 32 bits on store
// [RULE11] Coprocessor returns 64 bits on store
// [RULE12] Function field goes to numbered coprocessor
// [RULE13] Request carries location, attribute, size, flag
// [RULE14] Size code is byte count minus one
module lsap_path #(
    parameter int GPR_W = 64
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic big_endian,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [lsap_pkg::VA_W-1:0] virtual_location,
    input wire logic [lsap_pkg::SIZE_W-1:0] access_size_code,
    input wire logic fetch_or_data_flag,
    input wire logic [lsap_pkg::COP_NUM_W-1:0] coproc_num,
    input wire logic [lsap_pkg::REG_SEL_W-1:0] coproc_reg_select,
    input wire logic [lsap_pkg::FUNC_W-1:0] coproc_func,
    input wire logic [GPR_W-1:0] store_data,
    input wire logic tlb_wr_en,
    input wire logic [$clog2(lsap_pkg::TLB_ENTRIES)-1:0] tlb_wr_idx,
    input wire logic [lsap_pkg::VA_W-lsap_pkg::PAGE_SHIFT-1:0] tlb_wr_vpn,
    input wire logic [lsap_pkg::PA_W-lsap_pkg::PAGE_SHIFT-1:0] tlb_wr_ppn,
    input wire logic [lsap_pkg::CCA_W-1:0] tlb_wr_cca,
    input wire logic tlb_wr_load_ok,
    input wire logic tlb_wr_store_ok,
    input wire logic [63:0] coproc_store_value,
    input wire logic mem_ready,
    input wire logic [GPR_W-1:0] mem_rdata,
    output logic busy,
    output logic op_done,
    output logic [GPR_W-1:0] load_data,
    output logic translate_fault,
    output logic mem_req,
    output logic [lsap_pkg::PA_W-1:0] mem_phys_location,
    output logic [lsap_pkg::CCA_W-1:0] cacheability_attribute,
    output logic [lsap_pkg::SIZE_W-1:0] mem_size_code,
    output logic mem_fetch_or_data,
    output logic load_or_store_flag,
    output logic [GPR_W/8-1:0] mem_byte_en,
    output logic mem_fill_block,
    output logic [GPR_W-1:0] memory_element,
    output logic cp_load_word,
    output logic cp_load_double,
    output logic [63:0] cp_load_value,
    output logic cp_fn_valid,
    output logic [lsap_pkg::COP_NUM_W-1:0] cp_unit,
    output logic [lsap_pkg::REG_SEL_W-1:0] cp_reg_sel,
    output logic [lsap_pkg::FUNC_W-1:0] cp_func
);
    localparam int NB = GPR_W / 8;
    localparam int LB = $clog2(NB);

    typedef struct packed {
        lsap_pkg::lsap_state_e st;
        logic [2:0] op;
        logic [lsap_pkg::VA_W-1:0] va;
        logic [2:0] sz;
        logic fd;
        logic unmapped;
        logic busy;
        logic done;
        logic [GPR_W-1:0] ld;
        logic fault;
        logic req;
        logic [lsap_pkg::PA_W-1:0] pa;
        logic [lsap_pkg::CCA_W-1:0] cca;
        logic is_st;
        logic [NB-1:0] be;
        logic fill;
        logic [GPR_W-1:0] elem;
        logic cplw;
        logic cpld;
        logic [63:0] cpval;
        logic cpfn;
        logic [lsap_pkg::COP_NUM_W-1:0] unit;
        logic [lsap_pkg::REG_SEL_W-1:0] rsel;
        logic [lsap_pkg::FUNC_W-1:0] func;
    } lsap_state_s;

    lsap_state_s s_r;
    lsap_state_s s_nxt;

    logic lk_hit;
    logic [lsap_pkg::PA_W-lsap_pkg::PAGE_SHIFT-1:0] lk_ppn;
    logic [lsap_pkg::CCA_W-1:0] lk_cca;
    logic lk_load_ok;
    logic lk_store_ok;
    logic [lsap_pkg::VA_W-lsap_pkg::PAGE_SHIFT-1:0] lk_vpn;

    // Look up the incoming address while idle, so the registered result is ready in MEM
    assign lk_vpn = (s_r.st == lsap_pkg::LSAP_IDLE) ?
                    virtual_location[lsap_pkg::VA_W-1:lsap_pkg::PAGE_SHIFT] :
                    s_r.va[lsap_pkg::VA_W-1:lsap_pkg::PAGE_SHIFT];

    lsap_tlb_mem u_tlb (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr_en(tlb_wr_en),
        .wr_idx(tlb_wr_idx),
        .wr_vpn(tlb_wr_vpn),
        .wr_ppn(tlb_wr_ppn),
        .wr_cca(tlb_wr_cca),
        .wr_load_ok(tlb_wr_load_ok),
        .wr_store_ok(tlb_wr_store_ok),
        .lk_vpn(lk_vpn),
        .lk_hit(lk_hit),
        .lk_ppn(lk_ppn),
        .lk_cca(lk_cca),
        .lk_load_ok(lk_load_ok),
        .lk_store_ok(lk_store_ok)
    );

    // Lanes in little-endian order first, then mirrored for big-endian
    function automatic logic [NB-1:0] lanes(input logic [2:0] sz, input logic [LB-1:0] lo,
                                            input logic be_mode);
        logic [NB-1:0] m;
        logic [NB-1:0] r;
        m = '0;
        r = '0;
        for (int i = 0; i < NB; i++) begin
            if (i >= int'(lo) && i <= int'(lo) + int'(sz)) begin // [RULE2] [RULE14]
                m[i] = 1'b1;
            end
        end
        for (int i = 0; i < NB; i++) begin
            r[i] = be_mode ? m[NB-1-i] : m[i]; // [RULE1]
        end
        return r;
    endfunction

    logic ld_op;
    logic st_op;
    logic allowed;
    logic [lsap_pkg::PA_W-1:0] pa_calc;
    logic [lsap_pkg::CCA_W-1:0] cca_calc;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.fault = 1'b0;
        s_nxt.cplw = 1'b0;
        s_nxt.cpld = 1'b0;
        s_nxt.cpfn = 1'b0;
        ld_op = (s_r.op == lsap_pkg::OP_LOAD) || (s_r.op == lsap_pkg::OP_CP_LW) ||
                (s_r.op == lsap_pkg::OP_CP_LD);
        st_op = !ld_op;
        allowed = ld_op ? lk_load_ok : lk_store_ok;
        if (s_r.unmapped) begin
            pa_calc = s_r.va[lsap_pkg::PA_W-1:0]; // [RULE6]
            cca_calc = s_r.va[lsap_pkg::UNMAPPED_CCA_POS +: lsap_pkg::CCA_W]; // [RULE6]
        end else begin
            pa_calc = {lk_ppn, s_r.va[lsap_pkg::PAGE_SHIFT-1:0]};
            cca_calc = lk_cca;
        end
        case (s_r.st)
            lsap_pkg::LSAP_IDLE: begin
                if (op_valid) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.op = op_code;
                    s_nxt.va = virtual_location;
                    s_nxt.fd = fetch_or_data_flag;
                    s_nxt.unit = coproc_num;
                    s_nxt.rsel = coproc_reg_select;
                    s_nxt.func = coproc_func;
                    s_nxt.unmapped = virtual_location[lsap_pkg::VA_W-1 -: 2] ==
                                     lsap_pkg::UNMAPPED_TAG;
                    case (op_code)
                        lsap_pkg::OP_CP_LW, lsap_pkg::OP_CP_SW: s_nxt.sz = lsap_pkg::SZ_WORD;
                        lsap_pkg::OP_CP_LD, lsap_pkg::OP_CP_SD: s_nxt.sz = lsap_pkg::SZ_DOUBLE;
                        default: s_nxt.sz = access_size_code;
                    endcase
                    if (op_code == lsap_pkg::OP_CP_SW) begin
                        s_nxt.elem = GPR_W'(coproc_store_value[31:0]); // [RULE10]
                    end else if (op_code == lsap_pkg::OP_CP_SD) begin
                        s_nxt.elem = GPR_W'(coproc_store_value); // [RULE11]
                    end else begin
                        s_nxt.elem = store_data;
                    end
                    if (op_code == lsap_pkg::OP_CP_FN) begin
                        s_nxt.cpfn = 1'b1; // [RULE12]
                        s_nxt.done = 1'b1;
                        s_nxt.busy = 1'b0;
                    end else begin
                        s_nxt.st = lsap_pkg::LSAP_MEM;
                    end
                end
            end
            lsap_pkg::LSAP_MEM: begin
                // Table result is valid one cycle after capture
                if (!s_r.unmapped && (!lk_hit || !allowed)) begin
                    s_nxt.fault = 1'b1; // [RULE7]
                    s_nxt.done = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = lsap_pkg::LSAP_IDLE;
                end else begin
                    s_nxt.req = 1'b1; // [RULE13]
                    s_nxt.pa = pa_calc;
                    s_nxt.cca = cca_calc;
                    s_nxt.is_st = st_op;
                    s_nxt.be = lanes(s_r.sz, s_r.va[LB-1:0], big_endian);
                    // Cached loads fetch at least the whole element
                    s_nxt.fill = ld_op && cca_calc != lsap_pkg::CCA_UNCACHED; // [RULE5]
                    if (ld_op && cca_calc != lsap_pkg::CCA_UNCACHED) begin
                        s_nxt.be = '1; // [RULE5]
                    end
                    s_nxt.st = lsap_pkg::LSAP_DONE;
                end
            end
            lsap_pkg::LSAP_DONE: begin
                if (mem_ready) begin
                    s_nxt.req = 1'b0;
                    s_nxt.fill = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = lsap_pkg::LSAP_IDLE;
                    if (ld_op) begin
                        // Uncached: only referenced lanes valid, others zero
                        for (int i = 0; i < NB; i++) begin
                            s_nxt.ld[i*8 +: 8] = s_r.be[i] ? mem_rdata[i*8 +: 8] : 8'h0; // [RULE4]
                        end
                        if (s_r.fill) begin
                            s_nxt.ld = mem_rdata; // [RULE3]
                        end
                    end
                    if (s_r.op == lsap_pkg::OP_CP_LW) begin
                        s_nxt.cplw = 1'b1;
                        s_nxt.cpval = 64'(mem_rdata[31:0]); // [RULE8]
                    end
                    if (s_r.op == lsap_pkg::OP_CP_LD) begin
                        s_nxt.cpld = 1'b1;
                        s_nxt.cpval = 64'(mem_rdata); // [RULE9]
                    end
                end
            end
            default: s_nxt.st = lsap_pkg::LSAP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign op_done = s_r.done;
    assign load_data = s_r.ld;
    assign translate_fault = s_r.fault;
    assign mem_req = s_r.req;
    // Naturally aligned element address
    assign mem_phys_location = {s_r.pa[lsap_pkg::PA_W-1:LB], LB'(0)}; // [RULE3]
    assign cacheability_attribute = s_r.cca;
    assign mem_size_code = s_r.sz;
    assign mem_fetch_or_data = s_r.fd;
    assign load_or_store_flag = s_r.is_st;
    assign mem_byte_en = s_r.be;
    assign mem_fill_block = s_r.fill;
    assign memory_element = s_r.elem;
    assign cp_load_word = s_r.cplw;
    assign cp_load_double = s_r.cpld;
    assign cp_load_value = s_r.cpval;
    assign cp_fn_valid = s_r.cpfn;
    assign cp_unit = s_r.unit;
    assign cp_reg_sel = s_r.rsel;
    assign cp_func = s_r.func;
endmodule

/* File: src/lsap_tlb_mem.sv */
`timescale 1ns/1ns
// Small translation table; lookup result comes out registered
module lsap_tlb_mem #(
    parameter int ENTRIES = lsap_pkg::TLB_ENTRIES,
    parameter int VPN_W = lsap_pkg::VA_W - lsap_pkg::PAGE_SHIFT,
    parameter int PPN_W = lsap_pkg::PA_W - lsap_pkg::PAGE_SHIFT
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [$clog2(ENTRIES)-1:0] wr_idx,
    input wire logic [VPN_W-1:0] wr_vpn,
    input wire logic [PPN_W-1:0] wr_ppn,
    input wire logic [lsap_pkg::CCA_W-1:0] wr_cca,
    input wire logic wr_load_ok,
    input wire logic wr_store_ok,
    input wire logic [VPN_W-1:0] lk_vpn,
    output logic lk_hit,
    output logic [PPN_W-1:0] lk_ppn,
    output logic [lsap_pkg::CCA_W-1:0] lk_cca,
    output logic lk_load_ok,
    output logic lk_store_ok
);
    logic [ENTRIES-1:0] valid_r;
    logic [VPN_W-1:0] vpn_r [ENTRIES];
    logic [PPN_W+lsap_pkg::CCA_W+1:0] dat_r [ENTRIES];
    logic [ENTRIES-1:0] match;
    logic [PPN_W+lsap_pkg::CCA_W+1:0] sel;

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_ent
            assign match[g] = valid_r[g] && (vpn_r[g] == lk_vpn);
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    valid_r[g] <= 1'b0;
                    vpn_r[g] <= '0;
                    dat_r[g] <= '0;
                end else if (wr_en && wr_idx == g) begin
                    valid_r[g] <= 1'b1;
                    vpn_r[g] <= wr_vpn;
                    dat_r[g] <= {wr_ppn, wr_cca, wr_load_ok, wr_store_ok};
                end
            end
        end
    endgenerate

    always_comb begin
        sel = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (match[i]) begin
                sel = dat_r[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lk_hit <= 1'b0;
            {lk_ppn, lk_cca, lk_load_ok, lk_store_ok} <= '0;
        end else begin
            lk_hit <= |match;
            {lk_ppn, lk_cca, lk_load_ok, lk_store_ok} <= sel;
        end
    end
endmodule

/* File: tb/lsap_mem_model.sv */
`timescale 1ns/1ns
module lsap_mem_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [lsap_pkg::PA_W-1:0] mem_phys_location,
    output logic mem_ready,
    output logic [63:0] mem_rdata
);
    int wait_n = 0;
    initial begin
        mem_ready = 1'b0;
        mem_rdata = 64'h0;
    end
    always @(posedge ref_clk) begin
        #1;
        if (mem_ready || !mem_req) begin
            mem_ready = 1'b0;
            // Released data bus must not keep looking valid
            mem_rdata = ~mem_rdata;
            wait_n = 0;
        end else if (wait_n < (slow ? 3 : 0)) begin
            wait_n++;
        end else begin
            mem_ready = 1'b1;
            mem_rdata = {mem_phys_location[31:0] ^ 32'hc3a5_96e1, mem_phys_location[31:0]};
        end
    end
endmodule

/* File: tb/lsap_monitor.sv */
`timescale 1ns/1ns
module lsap_monitor #(
    parameter int GPR_W = 64
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic op_valid,
    input wire logic busy,
    input wire logic [2:0] op_code,
    input wire logic [lsap_pkg::VA_W-1:0] virtual_location,
    input wire logic [lsap_pkg::COP_NUM_W-1:0] coproc_num,
    input wire logic [lsap_pkg::FUNC_W-1:0] coproc_func,
    input wire logic op_done,
    input wire logic translate_fault,
    input wire logic mem_req,
    input wire logic mem_ready,
    input wire logic [lsap_pkg::PA_W-1:0] mem_phys_location,
    input wire logic [lsap_pkg::CCA_W-1:0] cacheability_attribute,
    input wire logic [lsap_pkg::SIZE_W-1:0] mem_size_code,
    input wire logic load_or_store_flag,
    input wire logic [GPR_W/8-1:0] mem_byte_en,
    input wire logic mem_fill_block,
    input wire logic cp_load_double,
    input wire logic cp_fn_valid,
    input wire logic [lsap_pkg::COP_NUM_W-1:0] cp_unit,
    input wire logic [lsap_pkg::FUNC_W-1:0] cp_func
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic take;
    assign take = op_valid && !busy;
    fault_no_req_a: assert property (translate_fault |-> op_done && !mem_req)
        else $error("fault raised alongside a memory request");
    elem_align_a: assert property (mem_req |-> mem_phys_location[2:0] == 3'h0)
        else $error("memory element not aligned");
    unmapped_map_a: assert property (take && op_code == lsap_pkg::OP_LOAD
        && virtual_location[63:62] == lsap_pkg::UNMAPPED_TAG |-> ##2 mem_req
        && mem_phys_location == ($past(virtual_location[39:0], 2) & ~40'h7)
        && cacheability_attribute == $past(virtual_location[61:59], 2))
        else $error("direct translation wrong");
    uncached_lanes_a: assert property (mem_req
        && cacheability_attribute == lsap_pkg::CCA_UNCACHED
        |-> !mem_fill_block && $countones(mem_byte_en) == mem_size_code + 1)
        else $error("uncached lane count wrong");
    cached_fill_a: assert property (mem_req && !load_or_store_flag
        && cacheability_attribute != lsap_pkg::CCA_UNCACHED |-> mem_fill_block && &mem_byte_en)
        else $error("cached miss fill smaller than element");
    req_hold_a: assert property (mem_req && !mem_ready |=> mem_req
        && $stable(mem_phys_location) && $stable(mem_byte_en) && $stable(mem_size_code))
        else $error("request dropped or changed before answer");
    cp_double_a: assert property (take && op_code == lsap_pkg::OP_CP_LD
        |-> ##[2:14] cp_load_double)
        else $error("coprocessor double load not delivered");
    cp_func_a: assert property (take && op_code == lsap_pkg::OP_CP_FN
        |=> cp_fn_valid && cp_func == $past(coproc_func) && cp_unit == $past(coproc_num))
        else $error("function not forwarded to unit");
    cover property (mem_req && mem_ready);
    cover property (translate_fault);
    cover property (cp_fn_valid);
endmodule

bind lsap_path lsap_monitor #(.GPR_W(GPR_W)) u_mon (.*);

/* File: tb/lsap_tb.sv */
`timescale 1ns/1ns
module testbench;
    typedef struct {logic [56:0] rq; logic [70:0] d; logic [3:0] fl; logic [2:0] sel;} lsap_note_s;
    logic ref_clk, rstn, big_endian, op_valid, fetch_or_data_flag, tlb_wr_en, slow;
    logic tlb_wr_load_ok, tlb_wr_store_ok, mem_ready, busy, op_done, translate_fault, mem_req;
    logic mem_fetch_or_data, load_or_store_flag, mem_fill_block, cp_load_word, cp_load_double;
    logic cp_fn_valid;
    logic [2:0] op_code, access_size_code, tlb_wr_cca, cacheability_attribute, mem_size_code;
    logic [2:0] tlb_wr_idx;
    logic [63:0] virtual_location, store_data, coproc_store_value, mem_rdata, load_data;
    logic [63:0] memory_element, cp_load_value;
    logic [1:0] coproc_num, cp_unit;
    logic [4:0] coproc_reg_select, cp_reg_sel;
    logic [24:0] coproc_func, cp_func;
    logic [51:0] tlb_wr_vpn, base;
    logic [27:0] tlb_wr_ppn;
    logic [39:0] mem_phys_location;
    logic [7:0] mem_byte_en;
    logic [56:0] rq = '0;
    lsap_note_s notes[$];
    lsap_note_s wn;
    int n_fail = 0;
    int check_count = 0;
    lsap_path #(.GPR_W(64)) uut (.*);
    lsap_mem_model mem (.*);
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [7:0] lanes(input logic [2:0] a, input logic [2:0] s);
        logic [7:0] m;
        m = 8'h0;
        for (int i = 0; i < 8; i++)
            if (i >= a && i <= a + s) m[big_endian ? 7 - i : i] = 1'b1;
        return m;
    endfunction
    task automatic op(input logic [2:0] c, input logic [63:0] va, input logic [2:0] sz,
            input logic [39:0] pa, input logic [2:0] cca, input logic flt);
        lsap_note_s n;
        logic [2:0] s;
        logic [7:0] be;
        logic [63:0] p;
        logic [63:0] el;
        logic ld;
        int k;
        @(posedge ref_clk);
        #1;
        {fetch_or_data_flag, coproc_num, coproc_reg_select} = 8'($urandom);
        coproc_func = 25'($urandom);
        store_data = {$urandom, $urandom};
        coproc_store_value = {$urandom, $urandom};
        s = (c == lsap_pkg::OP_CP_LW || c == lsap_pkg::OP_CP_SW) ? 3'h3 : sz;
        s = (c == lsap_pkg::OP_CP_LD || c == lsap_pkg::OP_CP_SD) ? 3'h7 : s;
        ld = c == lsap_pkg::OP_LOAD || c == lsap_pkg::OP_CP_LW || c == lsap_pkg::OP_CP_LD;
        // Only cached loads fetch the whole element; stores keep their own lanes
        be = (ld && cca != lsap_pkg::CCA_UNCACHED) ? 8'hff : lanes(va[2:0], s);
        el = (c == lsap_pkg::OP_CP_SD) ? coproc_store_value : store_data;
        el = (c == lsap_pkg::OP_CP_SW) ? {32'h0, coproc_store_value[31:0]} : el;
        p = {pa[31:3] ^ 29'h1874_b2dc, 3'h1, pa[31:3], 3'h0};
        for (k = 0; k < 8; k++)
            if (!be[k]) p[8*k+:8] = 8'h0;
        n.rq = (flt || c == lsap_pkg::OP_CP_FN) ? '0 : {pa & ~40'h7, cca, s, be,
            ld && cca != lsap_pkg::CCA_UNCACHED, c == 3'h1 || c == 3'h4 || c == 3'h5,
            fetch_or_data_flag};
        n.fl = flt ? 4'h8 : (c == 3'h2) ? 4'h4 : (c == 3'h3) ? 4'h2 : (c == 3'h6) ? 4'h1 : 4'h0;
        n.sel = (flt || c == 3'h1 || c == 3'h4 || c == 3'h5) ? 3'h4 : c - 3'h1;
        n.sel = (c == lsap_pkg::OP_LOAD && !flt) ? 3'h0 : n.sel;
        n.d = {coproc_num, coproc_reg_select,
            (c == 3'h6) ? {39'h0, coproc_func} : (n.sel == 3'h4) ? el : p};
        notes.push_back(n);
        op_code = c;
        virtual_location = va;
        access_size_code = sz;
        op_valid = 1'b1;
        @(posedge ref_clk);
        #1 op_valid = 1'b0;
        for (k = 0; k < 60 && op_done !== 1'b1; k++)
            @(negedge ref_clk);
        if (k == 60) begin
            chk("completion wait", 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask
    always @(negedge ref_clk) begin
        if (mem_req === 1'b1 && mem_ready === 1'b1)
            rq = {mem_phys_location, cacheability_attribute, mem_size_code, mem_byte_en,
                mem_fill_block, load_or_store_flag, mem_fetch_or_data};
        if (op_done === 1'b1) begin
            chk("pending note", notes.size() != 0, 1'b1);
            wn = notes.pop_front();
            chk("request", rq, wn.rq);
            chk("flags", {busy, translate_fault, cp_load_word, cp_load_double, cp_fn_valid},
                {1'b0, wn.fl});
            case (wn.sel)
                3'h0: chk("load data", load_data, wn.d[63:0]);
                3'h1: chk("cp word", {cp_unit, cp_reg_sel, cp_load_value[31:0]}, {wn.d[70:64], wn.d[31:0]});
                3'h2: chk("cp double", {cp_unit, cp_reg_sel, cp_load_value}, wn.d);
                3'h4: chk("store element", memory_element, wn.d[63:0]);
                3'h5: chk("cp func", {cp_unit, cp_func}, {wn.d[70:69], wn.d[24:0]});
                default: ;
            endcase
            rq = '0;
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        logic [2:0] sz, cc;
        logic [39:0] pa;
        void'($urandom(64471));
        {rstn, big_endian, op_valid, op_code, virtual_location, access_size_code, slow} = '0;
        {fetch_or_data_flag, coproc_num, coproc_reg_select, coproc_func, store_data} = '0;
        {coproc_store_value, tlb_wr_en, tlb_wr_idx, tlb_wr_vpn, tlb_wr_ppn} = '0;
        {tlb_wr_cca, tlb_wr_load_ok, tlb_wr_store_ok} = '0;
        repeat (16) @(posedge ref_clk);
        #1 rstn = 1'b1;
        for (int i = 0; i < 40; i++) begin
            big_endian = 1'($urandom);
            slow = 1'($urandom);
            sz = 3'($urandom);
            cc = (i % 3 == 0 || i[0]) ? lsap_pkg::CCA_UNCACHED : 3'($urandom);
            pa = {$urandom, 5'($urandom), 3'($urandom % (8 - sz))};
            op(3'(i[0]), {lsap_pkg::UNMAPPED_TAG, cc, 19'($urandom), pa}, sz, pa, cc, 1'b0);
        end
        base = {2'h0, 18'($urandom), $urandom} | 52'h10;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            #1 tlb_wr_en = 1'b1;
            tlb_wr_idx = 3'(i);
            tlb_wr_vpn = base + 52'(i);
            tlb_wr_ppn = 28'($urandom);
            tlb_wr_cca = i[1] ? lsap_pkg::CCA_UNCACHED : 3'h3;
            tlb_wr_load_ok = i[0];
            tlb_wr_store_ok = !i[0];
            @(posedge ref_clk);
            #1 tlb_wr_en = 1'b0;
            pa = {tlb_wr_ppn, 12'($urandom)};
            op(lsap_pkg::OP_LOAD, {tlb_wr_vpn, pa[11:0]}, 3'h0, pa, tlb_wr_cca, !i[0]);
            op(lsap_pkg::OP_STORE, {tlb_wr_vpn, pa[11:0]}, 3'h0, pa, tlb_wr_cca, i[0]);
        end
        op(lsap_pkg::OP_LOAD, {base + 52'h9, 12'h0}, 3'h0, 40'h0, 3'h0, 1'b1);
        big_endian = 1'b0;
        for (int i = 0; i < 10; i++) begin
            slow = i[0];
            pa = {$urandom, 5'($urandom), 3'h0};
            op(3'(2 + i / 2), {lsap_pkg::UNMAPPED_TAG, 3'h3, 19'h0, pa}, 3'h0, pa, 3'h3, 1'b0);
        end
        tally_and_finish();
    end
endmodule
